/* src/reset_gen_pkg.sv */
// Constants for the central reset generation and recording block.
// Assumes a single 125 MHz clock and an AXI4-Lite master for the registers.
package reset_gen_pkg;
   // Register byte offsets
   localparam logic [7:0] cause_addr = 8'h00;
   localparam logic [7:0] control_addr = 8'h04;
   localparam logic [7:0] status_addr = 8'h08;
   // Cause record bit positions
   localparam int cause_always_on_power = 0;
   localparam int cause_core_power = 1;
   localparam int cause_reset_pin = 2;
   localparam int cause_watchdog = 3;
   localparam int cause_software = 4;
   localparam int cause_sleep_wake = 5;
   localparam int cause_option_load_fail = 6;
   localparam int cause_lockup = 7;
   localparam int cause_width = 8;
   localparam logic [cause_width-1:0] cause_reset_value = 8'h01;
   // Control register bits
   localparam int ctl_debug_port_disable = 0;
   localparam int ctl_serial_wire_mode = 1;
   // Status register bits
   localparam int st_fail_count_lsb = 0;
   localparam int st_option_halted = 2;
   localparam int st_readout_forced = 3;
   localparam int st_emulated_sleep = 4;
   localparam int st_lockup = 5;
   localparam logic [1:0] option_fail_limit = 2'h3;
   // Release synchroniser depth, in clock cycles
   localparam int release_stages = 2;
   // Reset output indices
   localparam int out_full_core = 0;
   localparam int out_core_only = 1;
   localparam int out_access_port = 2;
   localparam int out_always_on = 3;
   localparam int out_core_periph = 4;
   localparam int out_count = 5;
   localparam logic [1:0] axi_okay = 2'h0;
   localparam logic [1:0] axi_slverr = 2'h2;
   typedef enum logic [1:0] {sleep_awake, sleep_normal, sleep_emulated} sleep_state_t;
endpackage : reset_gen_pkg

/* src/reset_generation_and_recording.sv */
// Central reset generation: merges reset sources into five reset outputs,
// records the last restart cause, retries option loading and gates test-port reset.
// Assumes all source inputs are synchronous to clock_in; always-on power detect
// drives rst_in rather than an input of its own.
`default_nettype none
module reset_generation_and_recording (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic core_power_detect_in,
   input wire logic reset_pin_low_in,
   input wire logic watchdog_expired_in,
   input wire logic core_software_reset_request_in,
   input wire logic option_check_done_in,
   input wire logic option_check_failed_in,
   input wire logic debug_reset_request_bit_in,
   input wire logic test_port_reset_low_in,
   input wire logic sleep_enter_in,
   input wire logic sleep_emulated_in,
   input wire logic sleep_wake_in,
   input wire logic core_lockup_in,
   output logic full_core_reset_out,
   output logic core_only_reset_out,
   output logic access_port_reset_out,
   output logic always_on_periph_reset_out,
   output logic core_periph_reset_out,
   output logic tap_reset_out,
   output logic option_reload_out,
   output logic readout_protect_forced_out,
   output logic core_halt_out,
   output logic flash_power_off_out,
   output logic core_power_off_out,
   output logic ram_retain_out,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   reset_gen_pkg::sleep_state_t sleep_state;
   logic [reset_gen_pkg::cause_width-1:0] cause;
   logic [1:0] fail_count;
   logic option_halted;
   logic lockup;
   logic [1:0] control;
   logic in_sleep;
   logic sleep_reset;
   logic core_power_loss;
   logic [reset_gen_pkg::out_count-1:0] reset_request;
   logic [reset_gen_pkg::out_count-1:0] reset_sync;
   logic [reset_gen_pkg::out_count-1:0] restart_event;
   logic any_restart;
   logic [reset_gen_pkg::cause_width-1:0] next_cause;

   assign in_sleep = (sleep_state != reset_gen_pkg::sleep_awake);
   // Held from entry request through wake until core power is reported good
   assign sleep_reset = in_sleep | sleep_enter_in | ~core_power_detect_in;
   assign core_power_loss = ~core_power_detect_in;

   // Sleep state tracking; the final option failure parks in emulated sleep
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         sleep_state <= reset_gen_pkg::sleep_awake;
      end else if (option_halted && sleep_state == reset_gen_pkg::sleep_awake) begin
         sleep_state <= reset_gen_pkg::sleep_emulated;
      end else begin
         unique case (sleep_state)
            reset_gen_pkg::sleep_awake: begin
               if (sleep_enter_in) begin
                  sleep_state <= sleep_emulated_in ? reset_gen_pkg::sleep_emulated
                                                   : reset_gen_pkg::sleep_normal;
               end
            end
            reset_gen_pkg::sleep_normal,
            reset_gen_pkg::sleep_emulated: begin
               // Release only once core power is reliable again
               if (sleep_wake_in && core_power_detect_in) begin
                  sleep_state <= reset_gen_pkg::sleep_awake;
               end
            end
            default: begin
               sleep_state <= reset_gen_pkg::sleep_awake;
            end
         endcase
      end
   end

   // Power switches: emulated sleep keeps core and memory supplied
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         flash_power_off_out <= 1'b0;
         core_power_off_out <= 1'b0;
         ram_retain_out <= 1'b0;
      end else begin
         flash_power_off_out <= (sleep_state == reset_gen_pkg::sleep_normal);
         core_power_off_out <= (sleep_state == reset_gen_pkg::sleep_normal);
         ram_retain_out <= (sleep_state == reset_gen_pkg::sleep_normal);
      end
   end

   // Option load retries; counter survives the restarts it causes
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         fail_count <= 2'h0;
         option_halted <= 1'b0;
      end else if (option_check_done_in && !option_halted) begin
         if (option_check_failed_in) begin
            fail_count <= fail_count + 2'h1;
            if (fail_count + 2'h1 == reset_gen_pkg::option_fail_limit) begin
               option_halted <= 1'b1;
            end
         end else begin
            fail_count <= 2'h0;
         end
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         readout_protect_forced_out <= 1'b0;
      end else begin
         readout_protect_forced_out <= option_halted;
      end
   end

   // Lockup halts the core and is flagged, but never requests a reset
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         lockup <= 1'b0;
      end else if (core_lockup_in) begin
         lockup <= 1'b1;
      end else if (reset_request[reset_gen_pkg::out_core_only]) begin
         lockup <= 1'b0;
      end
   end
   assign core_halt_out = lockup;

   // Source-to-output map, each output the OR of its sources
   logic option_error;
   assign option_error = option_check_done_in & option_check_failed_in & ~option_halted;
   always_comb begin
      reset_request = '0;
      reset_request[reset_gen_pkg::out_full_core] = core_power_loss | ~reset_pin_low_in
         | option_error | (sleep_reset && sleep_state != reset_gen_pkg::sleep_emulated
         && !sleep_emulated_in);
      reset_request[reset_gen_pkg::out_core_only] = core_power_loss | ~reset_pin_low_in
         | watchdog_expired_in | core_software_reset_request_in | option_error
         | sleep_reset | debug_reset_request_bit_in;
      reset_request[reset_gen_pkg::out_access_port] = core_power_loss
         | (sleep_reset && sleep_state != reset_gen_pkg::sleep_emulated
         && !sleep_emulated_in);
      reset_request[reset_gen_pkg::out_always_on] = (core_power_loss && !in_sleep)
         | ~reset_pin_low_in | watchdog_expired_in
         | core_software_reset_request_in;
      reset_request[reset_gen_pkg::out_core_periph] = core_power_loss | ~reset_pin_low_in
         | watchdog_expired_in | core_software_reset_request_in | option_error
         | sleep_reset;
   end

   // Assert at the next edge, sync release; always-on power reset asserts all asynchronously via rst_in
   genvar gi;
   generate
      for (gi = 0; gi < reset_gen_pkg::out_count; gi++) begin : g_release
         logic [reset_gen_pkg::release_stages-1:0] shift;
         always_ff @(posedge clock_in or posedge rst_in) begin
            if (rst_in) begin
               shift <= '1;
            end else if (reset_request[gi]) begin
               shift <= '1;
            end else begin
               shift <= {shift[reset_gen_pkg::release_stages-2:0], 1'b0};
            end
         end
         assign reset_sync[gi] = shift[reset_gen_pkg::release_stages-1];
         assign restart_event[gi] = reset_request[gi] & ~reset_sync[gi];
      end
   endgenerate

   assign full_core_reset_out = reset_sync[reset_gen_pkg::out_full_core];
   assign core_only_reset_out = reset_sync[reset_gen_pkg::out_core_only];
   assign access_port_reset_out = reset_sync[reset_gen_pkg::out_access_port];
   assign always_on_periph_reset_out = reset_sync[reset_gen_pkg::out_always_on];
   assign core_periph_reset_out = reset_sync[reset_gen_pkg::out_core_periph];
   assign any_restart = restart_event[reset_gen_pkg::out_core_only];
   assign option_reload_out = option_error;

   // Test-port reset touches the tap alone, and only in full test mode
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         tap_reset_out <= 1'b1;
      end else begin
         tap_reset_out <= ~test_port_reset_low_in
            & ~control[reset_gen_pkg::ctl_serial_wire_mode]
            & ~control[reset_gen_pkg::ctl_debug_port_disable];
      end
   end

   // Cause of the newest restart; the option flag keeps the earlier cause
   always_comb begin
      next_cause = cause;
      if (any_restart) begin
         next_cause = reset_gen_pkg::cause_reset_value;
         if (option_error) begin
            next_cause = cause;
            next_cause[reset_gen_pkg::cause_option_load_fail] = 1'b1;
         end else if (core_power_loss) begin
            next_cause[reset_gen_pkg::cause_core_power] = 1'b1;
         end else if (!reset_pin_low_in) begin
            next_cause[reset_gen_pkg::cause_reset_pin] = 1'b1;
         end else if (watchdog_expired_in) begin
            next_cause[reset_gen_pkg::cause_watchdog] = 1'b1;
         end else if (core_software_reset_request_in) begin
            next_cause[reset_gen_pkg::cause_software] = 1'b1;
         end else if (sleep_reset) begin
            next_cause[reset_gen_pkg::cause_sleep_wake] = 1'b1;
         end
      end
      if (lockup) begin
         next_cause[reset_gen_pkg::cause_lockup] = 1'b1;
      end
      next_cause[reset_gen_pkg::cause_always_on_power] = 1'b1;
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cause <= reset_gen_pkg::cause_reset_value;
      end else begin
         cause <= next_cause;
      end
   end

   // AXI4-Lite write: address and data taken in either order
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic w_lane0;
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_lane0 <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= reset_gen_pkg::axi_okay;
         control <= 2'h0;
      end else if (s_axi_bvalid) begin
         if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end else if (aw_held && w_held) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_bvalid <= 1'b1;
         if (aw_addr == reset_gen_pkg::control_addr) begin
            s_axi_bresp <= reset_gen_pkg::axi_okay;
            if (w_lane0) begin
               control <= w_data[1:0];
            end
         end else if (aw_addr == reset_gen_pkg::cause_addr
                      || aw_addr == reset_gen_pkg::status_addr) begin
            s_axi_bresp <= reset_gen_pkg::axi_okay;
         end else begin
            s_axi_bresp <= reset_gen_pkg::axi_slverr;
         end
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
         end
      end
   end

   // AXI4-Lite read: one cycle from address to data
   logic [7:0] ar_addr;
   assign ar_addr = {s_axi_araddr[7:2], 2'b00};
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= reset_gen_pkg::axi_okay;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else if (s_axi_arvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= reset_gen_pkg::axi_okay;
         s_axi_rdata <= 32'h0000_0000;
         unique case (ar_addr)
            reset_gen_pkg::cause_addr: begin
               s_axi_rdata[reset_gen_pkg::cause_width-1:0] <= cause;
            end
            reset_gen_pkg::control_addr: begin
               s_axi_rdata[1:0] <= control;
            end
            reset_gen_pkg::status_addr: begin
               s_axi_rdata[reset_gen_pkg::st_fail_count_lsb +: 2] <= fail_count;
               s_axi_rdata[reset_gen_pkg::st_option_halted] <= option_halted;
               s_axi_rdata[reset_gen_pkg::st_readout_forced] <= readout_protect_forced_out;
               s_axi_rdata[reset_gen_pkg::st_emulated_sleep] <=
                  (sleep_state == reset_gen_pkg::sleep_emulated);
               s_axi_rdata[reset_gen_pkg::st_lockup] <= lockup;
            end
            default: begin
               s_axi_rresp <= reset_gen_pkg::axi_slverr;
            end
         endcase
      end
   end
endmodule : reset_generation_and_recording
`default_nettype wire

/* verification/reset_gen_chk.sv */
// Assertion checker for the reset generation block, bound onto its ports.
// Assumes every reset source comes from flops on clock_in and rests inactive in rst_in (the active-low pins high).
`default_nettype none
module reset_gen_chk (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic reset_pin_low_in,
   input wire logic watchdog_expired_in,
   input wire logic core_software_reset_request_in,
   input wire logic option_check_failed_in,
   input wire logic option_reload_out,
   input wire logic debug_reset_request_bit_in,
   input wire logic test_port_reset_low_in,
   input wire logic core_lockup_in,
   input wire logic full_core_reset_out,
   input wire logic core_only_reset_out,
   input wire logic always_on_periph_reset_out,
   input wire logic core_periph_reset_out,
   input wire logic tap_reset_out,
   input wire logic core_halt_out
);
   default clocking @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   // Held two cycles so a one-cycle expiry still clears the core
   property p_wdog;
      watchdog_expired_in |=> (core_only_reset_out && core_periph_reset_out) [*2];
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog reset not held");
   property p_soft;
      core_software_reset_request_in |=> core_only_reset_out && always_on_periph_reset_out;
   endproperty
   a_soft: assert property (p_soft) else $error("software reset missing");
   property p_pin;
      !reset_pin_low_in |=> full_core_reset_out && always_on_periph_reset_out;
   endproperty
   a_pin: assert property (p_pin) else $error("pin reset missing");
   property p_opt;
      option_reload_out |-> option_check_failed_in ##1 full_core_reset_out && core_only_reset_out;
   endproperty
   a_opt: assert property (p_opt) else $error("option error reset wrong");
   property p_dbg;
      debug_reset_request_bit_in |=> core_only_reset_out;
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug reset missing");
   property p_tap;
      $rose(tap_reset_out) |-> !$past(test_port_reset_low_in);
   endproperty
   a_tap: assert property (p_tap) else $error("tap reset without cause");
   property p_lock;
      core_lockup_in |=> core_halt_out;
   endproperty
   a_lock: assert property (p_lock) else $error("lockup not flagged");
   property p_rel;
      $fell(core_only_reset_out) |-> !$past(watchdog_expired_in);
   endproperty
   a_rel: assert property (p_rel) else $error("reset released too early");
endmodule : reset_gen_chk
`default_nettype wire

/* verification/far_side_model.sv */
// Far side: core, watchdog, option loader, power manager and debugger as one source driver.
// Assumes go_in is a one-cycle request made while the previous source has ended.
`default_nettype none
module far_side_model (
   input wire logic clock_in,
   input wire logic go_in,
   input wire logic [3:0] which_in,
   input wire logic [3:0] len_in,
   output logic [10:0] src_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] pulse = '0;
   logic [3:0] left = 4'h0;
   logic [3:0] dog = 4'h0;
   // One source at a time, so each event's mapping shows alone
   always_ff @(posedge clock_in) begin
      if (go_in && left == 4'h0) begin
         pulse <= 11'h001 << which_in;
         left <= len_in;
      end else if (left > 4'h1) begin
         left <= left - 4'h1;
      end else begin
         pulse <= '0;
         left <= 4'h0;
      end
   end
   // Watchdog left enabled, so a lockup ends in an expiry
   always_ff @(posedge clock_in) begin
      dog <= pulse[8] ? 4'h8 : (dog != 4'h0 ? dog - 4'h1 : 4'h0);
   end
   assign src_out = pulse | {10'h000, dog == 4'h1};
endmodule : far_side_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the reset generation block with the far-side source model.
// Assumes AXI4-Lite answers within a few cycles; all waits are bounded.
`default_nettype none
bind reset_generation_and_recording reset_gen_chk u_chk (
   .clock_in, .rst_in, .reset_pin_low_in, .watchdog_expired_in, .core_software_reset_request_in,
   .option_check_failed_in, .option_reload_out, .debug_reset_request_bit_in,
   .test_port_reset_low_in, .core_lockup_in, .full_core_reset_out, .core_only_reset_out,
   .always_on_periph_reset_out, .core_periph_reset_out, .tap_reset_out, .core_halt_out
);
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic go = 1'b0;
   logic tpr_low = 1'b1;
   logic [3:0] which = 4'h0;
   logic [3:0] len = 4'h0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, rd, ec;
   logic [31:0] seed = 32'h0000_2e26;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata;
   logic [31:0] a_cause = 32'(reset_gen_pkg::cause_addr);
   logic [31:0] a_ctl = 32'(reset_gen_pkg::control_addr);
   logic [10:0] src;
   logic [4:0] rv;
   logic tap, rpf, halt, fpo, cpo, ram;
   int err_total = 0;
   int n_tests = 0;
   always #4 clock_in = ~clock_in;
   far_side_model u_far (.clock_in, .go_in(go), .which_in(which), .len_in(len), .src_out(src));
   reset_generation_and_recording DUT (
      .clock_in, .rst_in, .core_power_detect_in(!src[4]), .reset_pin_low_in(!src[3]),
      .watchdog_expired_in(src[0]), .core_software_reset_request_in(src[1]),
      .option_check_done_in(src[5] | src[9]), .option_check_failed_in(src[5]),
      .debug_reset_request_bit_in(src[2]), .test_port_reset_low_in(tpr_low),
      .sleep_enter_in(src[6] | src[7]), .sleep_emulated_in(src[7]), .sleep_wake_in(src[10]),
      .core_lockup_in(src[8]), .full_core_reset_out(rv[0]), .core_only_reset_out(rv[1]),
      .access_port_reset_out(rv[2]), .always_on_periph_reset_out(rv[3]),
      .core_periph_reset_out(rv[4]), .tap_reset_out(tap), .option_reload_out(),
      .readout_protect_forced_out(rpf), .core_halt_out(halt), .flash_power_off_out(fpo),
      .core_power_off_out(cpo), .ram_retain_out(ram), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   // Output order: core periph, always-on, access port, core only, full core
   function automatic logic [4:0] exp_map(input int s);
      case (s)
         0, 1: return 5'h1a;
         2: return 5'h02;
         3: return 5'h1b;
         4: return 5'h1f;
         5: return 5'h13;
         default: return 5'h00;
      endcase
   endfunction : exp_map
   task automatic wrap_up(input logic hung);
      if (hung) begin
         err_total++;
         $display("Error wait expected answer seen none");
      end
      $display("Checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic fire(input int w, input int l);
      @(posedge clock_in);
      go <= 1'b1;
      which <= 4'(w);
      len <= 4'(l);
      @(posedge clock_in);
      go <= 1'b0;
   endtask : fire
   task automatic wait_rv(input logic busy);
      int n;
      n = 0;
      while ((|rv) !== busy && n < 40) begin
         @(posedge clock_in);
         n++;
      end
      if (n >= 40) wrap_up(1'b1);
   endtask : wait_rv
   // Each channel is released only at the edge that takes it
   task automatic axi(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      resp = 2'h3;
      @(posedge clock_in);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_arvalid <= !wr;
      s_axi_bready <= wr;
      s_axi_rready <= !wr;
      while (resp === 2'h3 && n < 40) begin
         @(posedge clock_in);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (wr ? s_axi_bvalid : s_axi_rvalid) begin
            resp = wr ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
         end
      end
      if (n >= 40) wrap_up(1'b1);
   endtask : axi
   initial begin
      int order [6] = '{2, 0, 1, 3, 4, 5};
      int cb [6] = '{0, 3, 4, 2, 1, 6};
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      chk("outputs idle", 32'h0000_0000, 32'(rv));
      seed = xs(seed);
      axi(1'b1, a_cause, seed);
      chk("cause write resp", 32'(reset_gen_pkg::axi_okay), 32'(resp));
      axi(1'b0, a_cause, 32'h0000_0000);
      chk("cause after reset", 32'h0000_0001, rd);
      axi(1'b0, 32'h0000_0010 + {27'h0, seed[2:0], 2'b00}, 32'h0000_0000);
      chk("unmapped resp", 32'(reset_gen_pkg::axi_slverr), 32'(resp));
      ec = 32'h0000_0001;
      foreach (order[i]) begin
         seed = xs(seed);
         fire(order[i], order[i] == 5 ? 1 : 1 + int'(seed[1:0]));
         wait_rv(1'b1);
         chk("outputs", 32'(exp_map(order[i])), 32'(rv));
         wait_rv(1'b0);
         axi(1'b0, a_cause, 32'h0000_0000);
         ec = order[i] == 5 ? ec | 32'h0000_0040 : (32'h0000_0001 << cb[i]) | 32'h0000_0001;
         if (order[i] != 2) chk("cause", ec, rd);
         $display("Source %0d done", order[i]);
      end
      fire(9, 1);
      for (int k = 0; k < 3; k++) begin
         fire(5, 1);
         repeat (6) @(posedge clock_in);
      end
      chk("third option failure", 32'h0000_0012, 32'(rv));
      chk("readout forced", 32'h0000_0001, 32'(rpf));
      axi(1'b0, 32'(reset_gen_pkg::status_addr), 32'h0000_0000);
      chk("option status", 32'h0000_001f, rd);
      $display("Option retry done");
      rst_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      chk("outputs in reset", 32'h0000_003f, {26'h0, tap, rv});
      rst_in <= 1'b0;
      fire(6, 1);
      repeat (4) @(posedge clock_in);
      chk("normal sleep", 32'h0000_0017, 32'(rv));
      chk("sleep power", 32'h0000_0007, {29'h0, fpo, cpo, ram});
      fire(4, 3);
      repeat (2) @(posedge clock_in);
      chk("power loss in sleep", 32'h0000_0017, 32'(rv));
      repeat (4) @(posedge clock_in);
      fire(10, 1);
      wait_rv(1'b0);
      axi(1'b0, a_cause, 32'h0000_0000);
      chk("wake cause", 32'h0000_0021, rd);
      fire(7, 1);
      repeat (4) @(posedge clock_in);
      chk("emulated sleep", 32'h0000_0012, 32'(rv));
      chk("flash kept powered", 32'h0000_0000, 32'(fpo));
      fire(10, 1);
      wait_rv(1'b0);
      $display("Sleep done");
      tpr_low <= 1'b0;
      repeat (3) @(posedge clock_in);
      chk("tap reset alone", 32'h0000_0020, {26'h0, tap, rv});
      for (int m = 1; m < 3; m++) begin
         axi(1'b1, a_ctl, 32'(m));
         repeat (3) @(posedge clock_in);
         chk("tap ignored", 32'h0000_0000, 32'(tap));
      end
      axi(1'b1, a_ctl, 32'h0000_0000);
      tpr_low <= 1'b1;
      fire(8, 1);
      repeat (3) @(posedge clock_in);
      chk("lockup halts only", 32'h0000_0020, {26'h0, halt, rv});
      wait_rv(1'b1);
      chk("watchdog after lockup", 32'h0000_001a, 32'(rv));
      wait_rv(1'b0);
      chk("halt cleared", 32'h0000_0000, 32'(halt));
      $display("Lockup done");
      wrap_up(1'b0);
   end
endmodule : tb
`default_nettype wire
